// file: hw/rsps_map.vh
// Strap capture and pin-ownership constants for the peripheral select block.
// Included by the select logic; definitions only.
`ifndef RSPS_MAP_VH
`define RSPS_MAP_VH

// Reset values of the held strap registers
`define RSPS_CELL_SEL_RST 1'h0
`define RSPS_PCI_SEL_RST 1'h0
`define RSPS_SER2_SEL_RST 1'h0
`define RSPS_AUTOINIT_RST 1'h0
`define RSPS_CFG_RST 10'h000

// Field positions inside the captured configuration word
`define RSPS_CFG_ADDR20_13_LSB 0
`define RSPS_CFG_ADDR20_13_MSB 7
`define RSPS_CFG_ADDR7_BIT 8
`define RSPS_CFG_HOST_WIDTH_BIT 9
`define RSPS_CFG_AUTOINIT_BIT 0

// GPIO pin positions with fixed default functions
`define RSPS_GP_DIV4_BIT 1
`define RSPS_GP_DIV6_BIT 2
`define RSPS_GP_SER2_CLK_BIT 8
`define RSPS_GP_INT_LSB 4
`define RSPS_GP_INT_MSB 7
`define RSPS_GP_UPPER_LSB 9
`define RSPS_GP_UPPER_MSB 15

// Strap synchroniser depth
`define RSPS_SYNC_STAGES 2

`endif

// file: hw/rsps_select.v
// Reset-latched peripheral selection and shared-pin ownership.
// Assumes strap pins are held by board resistors or a controller; GPIO
// enable/direction bits arrive from a software register elsewhere.
// Contract
// R1: Cell-port strap low at reset gives shared pins to serial port 1 and floats cell-only pins.
// R2: Cell-port strap high at reset enables the cell interface and floats serial-1-only pins.
// R3: PCI and serial-2 straps are both captured during reset and set host/GPIO/PCI/EEPROM/serial-2 use.
// R4: PCI strap low enables the host port, keeps PCI and EEPROM off, and frees upper GPIO.
// R5: PCI off puts shared pins on the host port and floats the byte-enable-0 and EEPROM select pins.
// R6: A shared pin is GPIO only with its enable bit set; direction bit clear is input, set is output.
// R7: PCI strap high disables the host port and gives all host/PCI and GPIO/PCI pins to PCI.
// R8: Serial port 2 is off only with PCI selected and serial-2 strap low; here it is also off until the capture window closes.
// R9: In that configuration the EEPROM auto-initialises PCI at reset only when its strap is high.
// R10: Serial-2 select raised after reset enables serial port 2 and disables the EEPROM live.
// R11: The outside party keeps the PCI strap valid and fixed; the serial-2 strap stays valid.
// R12: Timers, serial port 0 and lower GPIO pins are always available; here timers and serial port 0 are off until the capture window closes.
// R13: Pins 1, 2 and 8 default to div-4 clock, div-6 clock and serial-2 clock source.
// R14: Pins 7 to 4 default to interrupt inputs or input-only GPIO; here they drive out when enable and direction bits are both set.
// R15: GPIO/PCI shared pins default to no function until selected.
// R16: Remaining straps on address bits 20 to 13, 7 and host data bit 5 are captured in reset.
// R17: Captured straps other than serial-2 select are held until the next reset.
`timescale 1ns/10ps
`include "rsps_map.vh"
module rsps_select #(
  parameter GPIO_WIDTH = 16
) (
  input wire i_clk,
  input wire i_reset,
  input wire i_cell_port_select_strap,
  input wire i_pci_select_strap,
  input wire i_serial2_select_strap,
  input wire i_eeprom_autoinit_strap,
  input wire [7:0] i_strap_addr_bits_20_13,
  input wire i_strap_addr_bit7,
  input wire i_host_data_bit5_strap,
  input wire [GPIO_WIDTH-1:0] i_gpio_pin_enable_bit,
  input wire [GPIO_WIDTH-1:0] i_gpio_pin_direction_bit,
  output reg o_cell_port_enable,
  output reg o_serial1_enable,
  output reg o_cell_pins_oe,
  output reg o_serial1_pins_oe,
  output reg o_shared_cell_serial1_sel,
  output reg o_host_port_enable,
  output reg o_pci_enable,
  output reg o_pci_standalone_oe,
  output reg o_eeprom_enable,
  output reg o_eeprom_autoinit,
  output reg o_serial2_enable,
  output reg o_serial0_enable,
  output reg o_timers_enable,
  output reg [GPIO_WIDTH-1:0] o_gpio_func_gpio,
  output reg [GPIO_WIDTH-1:0] o_gpio_oe,
  output reg [GPIO_WIDTH-1:0] o_gpio_func_pci,
  output reg [GPIO_WIDTH-1:0] o_gpio_func_alt,
  output reg [7:0] o_cfg_addr_bits_20_13,
  output reg o_cfg_addr_bit7,
  output reg o_cfg_host_width32
);
  // Straps come from pins, so all pass a synchroniser first
  localparam SW = 12;
  wire [SW-1:0] strap_s;
  rsps_sync #(
    .WIDTH(SW)
  ) u_sync (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_async({i_host_data_bit5_strap, i_strap_addr_bit7, i_strap_addr_bits_20_13,
      i_eeprom_autoinit_strap, i_serial2_select_strap}),
    .o_sync(strap_s)
  );
  wire ser2_s = strap_s[0];
  wire ainit_s = strap_s[1];
  wire [7:0] addr_s = strap_s[9:2];
  wire addr7_s = strap_s[10];
  wire hwid_s = strap_s[11];

  // Cell and PCI selects share the same synchroniser style
  wire [1:0] sel_s;
  rsps_sync #(
    .WIDTH(2)
  ) u_sync_sel (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_async({i_pci_select_strap, i_cell_port_select_strap}),
    .o_sync(sel_s)
  );

  // Capture phase: first clocks after reset release, while synchroniser fills
  localparam ST_CAPT = 2'b01;
  localparam ST_RUN = 2'b10;
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [1:0] capt_cnt_r;
  reg [1:0] capt_cnt_nxt;
  reg cell_sel_r;
  reg pci_sel_r;
  reg ser2_init_r;
  reg ainit_r;
  reg [9:0] cfg_r;

  always @* begin
    state_nxt = state_r;
    capt_cnt_nxt = capt_cnt_r;
    case (state_r)
      ST_CAPT: begin
        capt_cnt_nxt = capt_cnt_r + 2'h1;
        // Wait for straps to pass both synchroniser stages
        if (capt_cnt_r == `RSPS_SYNC_STAGES) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        state_nxt = ST_RUN;
      end
      default: begin
        state_nxt = ST_CAPT;
        capt_cnt_nxt = 2'h0;
      end
    endcase
  end

  wire capturing = (state_r == ST_CAPT);

  // Straps are latched in the reset window, then frozen
  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      state_r <= ST_CAPT;
      capt_cnt_r <= 2'h0;
      cell_sel_r <= `RSPS_CELL_SEL_RST;
      pci_sel_r <= `RSPS_PCI_SEL_RST;
      ser2_init_r <= `RSPS_SER2_SEL_RST;
      ainit_r <= `RSPS_AUTOINIT_RST;
      cfg_r <= `RSPS_CFG_RST;
    end else begin
      state_r <= state_nxt;
      capt_cnt_r <= capt_cnt_nxt;
      if (capturing) begin
        cell_sel_r <= sel_s[0]; // R1 R2 R17
        pci_sel_r <= sel_s[1]; // R3 R17
        ser2_init_r <= ser2_s; // R3
        ainit_r <= ainit_s; // R9 R17
        cfg_r <= {hwid_s, addr7_s, addr_s}; // R16 R17
      end
    end
  end

  // Live serial-2 select; only it may move after reset, and it can fall back low only when its reset-time value was low
  wire ser2_live = capturing ? ser2_s : (ser2_init_r | ser2_s); // R10
  wire running = ~capturing;

  // Cell/serial-1 table; cell_sel_r is reloaded every clock of the window and held once it closes
  reg cell_en_nxt;
  reg ser1_en_nxt;
  reg cell_oe_nxt;
  reg ser1_oe_nxt;
  always @* begin
    cell_en_nxt = 1'b0;
    ser1_en_nxt = 1'b1;
    cell_oe_nxt = 1'b0;
    ser1_oe_nxt = 1'b0;
    case ({running, cell_sel_r})
      2'b10: begin
        // Serial 1 owns the shared pins; cell-only pins float
        ser1_oe_nxt = 1'b1; // R1
      end
      2'b11: begin
        // Cell port owns the shared pins; serial-1-only pins float
        cell_en_nxt = 1'b1; // R2
        ser1_en_nxt = 1'b0; // R2
        cell_oe_nxt = 1'b1; // R2
      end
      default: begin
        ser1_en_nxt = ~cell_sel_r; // R1
      end
    endcase
  end

  // Host/PCI/serial-2 table keyed by held PCI strap and live serial-2 select
  reg host_en_nxt;
  reg pci_en_nxt;
  reg eeprom_en_nxt;
  reg ser2_en_nxt;
  always @* begin
    host_en_nxt = 1'b0;
    pci_en_nxt = 1'b0;
    eeprom_en_nxt = 1'b0;
    ser2_en_nxt = 1'b0;
    case ({running, pci_sel_r, ser2_live})
      3'b100, 3'b101: begin
        host_en_nxt = 1'b1; // R4 R5
        ser2_en_nxt = 1'b1; // R8
      end
      3'b110: begin
        // Only combination that parks serial 2 and wakes the EEPROM
        pci_en_nxt = 1'b1; // R7
        eeprom_en_nxt = 1'b1; // R4 R8
      end
      3'b111: begin
        pci_en_nxt = 1'b1; // R7
        ser2_en_nxt = 1'b1; // R8 R10
      end
      default: begin
        // Window still open: nothing owns the shared pins yet
        host_en_nxt = 1'b0;
      end
    endcase
  end

  // Autoinit is armed only from the reset-time strap set
  wire autoinit_nxt = pci_sel_r & ~ser2_init_r & ainit_r & running; // R9

  // Per-pin ownership; each pin's role is fixed by its position
  wire [GPIO_WIDTH-1:0] gp_gpio_nxt;
  wire [GPIO_WIDTH-1:0] gp_oe_nxt;
  wire [GPIO_WIDTH-1:0] gp_pci_nxt;
  wire [GPIO_WIDTH-1:0] gp_alt_nxt;
  genvar g;
  generate
    for (g = 0; g < GPIO_WIDTH; g = g + 1) begin : g_pin
      localparam IS_UPPER = (g >= `RSPS_GP_UPPER_LSB) && (g <= `RSPS_GP_UPPER_MSB);
      localparam IS_CLKOUT = (g == `RSPS_GP_DIV4_BIT) || (g == `RSPS_GP_DIV6_BIT);
      localparam IS_SCLK = (g == `RSPS_GP_SER2_CLK_BIT);
      localparam IS_INT = (g >= `RSPS_GP_INT_LSB) && (g <= `RSPS_GP_INT_MSB);
      wire sw_en = i_gpio_pin_enable_bit[g];
      wire sw_out = i_gpio_pin_enable_bit[g] & i_gpio_pin_direction_bit[g];
      if (IS_UPPER) begin : g_up
        // No function until the window closes, then PCI or software owns it
        assign gp_gpio_nxt[g] = running & ~pci_sel_r & sw_en; // R4 R6 R15
        assign gp_oe_nxt[g] = running & ~pci_sel_r & sw_out; // R6
        assign gp_pci_nxt[g] = running & pci_sel_r; // R7 R15
        assign gp_alt_nxt[g] = 1'b0;
      end else begin : g_low
        // Lower pins never depend on strap selection
        assign gp_gpio_nxt[g] = sw_en; // R6 R12
        assign gp_pci_nxt[g] = 1'b0; // R12
        if (IS_CLKOUT) begin : g_clk
          // Clock outputs drive until software claims the pin
          assign gp_oe_nxt[g] = ~sw_en | i_gpio_pin_direction_bit[g]; // R13
          assign gp_alt_nxt[g] = ~sw_en; // R13
        end else if (IS_SCLK) begin : g_sclk
          assign gp_oe_nxt[g] = sw_out; // R6
          assign gp_alt_nxt[g] = ~sw_en; // R13
        end else if (IS_INT) begin : g_int
          // Interrupt role is always on input; output only when fully enabled
          assign gp_oe_nxt[g] = sw_out; // R6
          assign gp_alt_nxt[g] = ~sw_out; // R14
        end else begin : g_plain
          assign gp_oe_nxt[g] = sw_out; // R6
          assign gp_alt_nxt[g] = 1'b0;
        end
      end
    end
  endgenerate

  // Peripheral enables and standalone pin drives
  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_cell_port_enable <= 1'b0;
      o_serial1_enable <= 1'b1;
      o_cell_pins_oe <= 1'b0;
      o_serial1_pins_oe <= 1'b0;
      o_shared_cell_serial1_sel <= 1'b0;
      o_host_port_enable <= 1'b0;
      o_pci_enable <= 1'b0;
      o_pci_standalone_oe <= 1'b0;
      o_eeprom_enable <= 1'b0;
      o_eeprom_autoinit <= 1'b0;
      o_serial2_enable <= 1'b0;
      o_serial0_enable <= 1'b0;
      o_timers_enable <= 1'b0;
    end else begin
      o_cell_port_enable <= cell_en_nxt; // R2
      o_serial1_enable <= ser1_en_nxt; // R1
      o_shared_cell_serial1_sel <= cell_sel_r; // R1 R2
      // Standalone pins may drive only for their owner
      o_cell_pins_oe <= cell_oe_nxt; // R1
      o_serial1_pins_oe <= ser1_oe_nxt; // R2
      o_host_port_enable <= host_en_nxt; // R4 R5 R7
      o_pci_enable <= pci_en_nxt; // R7
      o_pci_standalone_oe <= pci_en_nxt; // R5
      o_eeprom_enable <= eeprom_en_nxt; // R4 R10
      o_eeprom_autoinit <= autoinit_nxt; // R9
      o_serial2_enable <= ser2_en_nxt; // R8 R10
      o_serial0_enable <= running; // R12
      o_timers_enable <= running; // R12
    end
  end

  // Shared GPIO pin ownership
  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_gpio_func_gpio <= {GPIO_WIDTH{1'b0}};
      o_gpio_oe <= {GPIO_WIDTH{1'b0}};
      o_gpio_func_pci <= {GPIO_WIDTH{1'b0}};
      o_gpio_func_alt <= {GPIO_WIDTH{1'b0}};
    end else begin
      o_gpio_func_gpio <= gp_gpio_nxt;
      o_gpio_oe <= gp_oe_nxt;
      o_gpio_func_pci <= gp_pci_nxt;
      o_gpio_func_alt <= gp_alt_nxt;
    end
  end

  // Held configuration straps; only a new reset changes them
  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_cfg_addr_bits_20_13 <= 8'h00;
      o_cfg_addr_bit7 <= 1'b0;
      o_cfg_host_width32 <= 1'b0;
    end else begin
      o_cfg_addr_bits_20_13 <= cfg_r[`RSPS_CFG_ADDR20_13_MSB:`RSPS_CFG_ADDR20_13_LSB]; // R16
      o_cfg_addr_bit7 <= cfg_r[`RSPS_CFG_ADDR7_BIT]; // R16
      o_cfg_host_width32 <= cfg_r[`RSPS_CFG_HOST_WIDTH_BIT]; // R16
    end
  end
endmodule // rsps_select

// file: hw/rsps_sync.v
// Two-flop synchroniser bank for strap pins.
// Assumes asynchronous pin levels; output is one clock domain.
`timescale 1ns/10ps
module rsps_sync #(
  parameter WIDTH = 4
) (
  input wire i_clk,
  input wire i_reset,
  input wire [WIDTH-1:0] i_async,
  output reg [WIDTH-1:0] o_sync
);
  reg [WIDTH-1:0] meta_r;

  // First stage feeds only the second stage
  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      meta_r <= {WIDTH{1'b0}};
      o_sync <= {WIDTH{1'b0}};
    end else begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end
endmodule // rsps_sync

// file: test/rsps_select_sva.sv
// Checker for strap-selected pin ownership.
// Assumes it is bound onto rsps_select.
`timescale 1ns/10ps
module rsps_select_sva #(
  parameter GPIO_WIDTH = 16
) (
  input wire i_clk,
  input wire i_reset,
  input wire i_serial2_select_strap,
  input wire [GPIO_WIDTH-1:0] i_gpio_pin_enable_bit,
  input wire o_cell_port_enable,
  input wire o_serial1_enable,
  input wire o_cell_pins_oe,
  input wire o_serial1_pins_oe,
  input wire o_shared_cell_serial1_sel,
  input wire o_host_port_enable,
  input wire o_pci_enable,
  input wire o_pci_standalone_oe,
  input wire o_eeprom_enable,
  input wire o_eeprom_autoinit,
  input wire o_serial2_enable,
  input wire o_serial0_enable,
  input wire o_timers_enable,
  input wire [GPIO_WIDTH-1:0] o_gpio_func_gpio,
  input wire [GPIO_WIDTH-1:0] o_gpio_func_pci
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  cell_mux_a: assert property (o_cell_port_enable |-> !o_serial1_enable &&
    !o_serial1_pins_oe && o_shared_cell_serial1_sel) else $error("cell mux");
  ser1_mux_a: assert property (o_serial1_enable |-> !o_cell_pins_oe &&
    !o_shared_cell_serial1_sel) else $error("serial1 mux");
  host_pci_a: assert property (!(o_host_port_enable && o_pci_enable)) else $error("host");
  host_float_a: assert property (o_host_port_enable |-> !o_pci_standalone_oe &&
    !o_eeprom_enable && o_gpio_func_pci == 0) else $error("pci float");
  eeprom_own_a: assert property (o_eeprom_enable |-> o_pci_enable && !o_serial2_enable)
    else $error("eeprom");
  autoinit_a: assert property (o_eeprom_autoinit |-> o_pci_enable) else $error("autoinit");
  pci_hold_a: assert property (o_pci_enable |=> o_pci_enable) else $error("pci held");
  ser2_live_a: assert property ($rose(i_serial2_select_strap) && o_pci_enable |->
    ##[1:4] (o_serial2_enable && !o_eeprom_enable)) else $error("serial2 live");
  gpio_en_a: assert property ((o_gpio_func_gpio & ~$past(i_gpio_pin_enable_bit)) == 0)
    else $error("gpio enable");
  always_on_a: assert property (o_pci_enable |-> o_serial0_enable && o_timers_enable)
    else $error("always on");
  cover property (o_cell_port_enable);
  cover property (o_eeprom_autoinit);
  cover property (o_pci_enable && o_serial2_enable);
endmodule // rsps_select_sva
bind rsps_select rsps_select_sva #(.GPIO_WIDTH(GPIO_WIDTH)) rsps_select_sva_inst (.i_clk,
  .i_reset, .i_serial2_select_strap, .i_gpio_pin_enable_bit, .o_cell_port_enable,
  .o_serial1_enable, .o_cell_pins_oe, .o_serial1_pins_oe, .o_shared_cell_serial1_sel,
  .o_host_port_enable, .o_pci_enable, .o_pci_standalone_oe, .o_eeprom_enable,
  .o_eeprom_autoinit, .o_serial2_enable, .o_serial0_enable, .o_timers_enable,
  .o_gpio_func_gpio, .o_gpio_func_pci);

// file: test/rsps_strap_model.sv
// Strap driver standing in for board resistors or a controller.
// Assumes the bench changes the PCI strap only in reset; the other straps may move after it.
`timescale 1ns/10ps
module rsps_strap_model (
  input wire i_clk,
  input wire [12:0] i_vec,
  output reg [12:0] o_straps
);
  initial o_straps = 13'h0000;
  // Registered, so a strap never moves between edges
  always @(posedge i_clk) begin
    o_straps <= i_vec;
  end
endmodule // rsps_strap_model

// file: test/tb_top.sv
// Self-checking bench for the strap peripheral select.
// Assumes straps come from rsps_strap_model; vec is cell,pci,ser2,addr8,a7,hwid.
`timescale 1ns/10ps
module tb_top;
  reg i_clk = 1'b0;
  reg i_reset = 1'b1;
  reg [12:0] vec = 13'h0000;
  reg [15:0] gen = 16'h0000;
  reg [15:0] gdir = 16'h0000;
  wire [12:0] st;
  wire [12:0] en;
  wire [15:0] fg, oe, fp, fa;
  wire [7:0] ca;
  wire c7, cw;
  integer err_total = 0;
  integer n_compared = 0;
  integer cyc = 0;
  integer i;
  reg [12:0] rv [0:4];
  reg [12:0] re [0:4];
  initial forever #4 i_clk = ~i_clk;
  rsps_strap_model rsps_strap_model_inst (.i_clk(i_clk), .i_vec(vec), .o_straps(st));
  rsps_select rsps_select_inst (.i_clk(i_clk), .i_reset(i_reset),
    .i_cell_port_select_strap(st[12]), .i_pci_select_strap(st[11]),
    .i_serial2_select_strap(st[10]), .i_eeprom_autoinit_strap(st[2]),
    .i_strap_addr_bits_20_13(st[9:2]), .i_strap_addr_bit7(st[1]),
    .i_host_data_bit5_strap(st[0]), .i_gpio_pin_enable_bit(gen),
    .i_gpio_pin_direction_bit(gdir), .o_cell_port_enable(en[12]), .o_serial1_enable(en[11]),
    .o_cell_pins_oe(en[10]), .o_serial1_pins_oe(en[9]), .o_shared_cell_serial1_sel(en[8]),
    .o_host_port_enable(en[7]), .o_pci_enable(en[6]), .o_pci_standalone_oe(en[5]),
    .o_eeprom_enable(en[4]), .o_eeprom_autoinit(en[3]), .o_serial2_enable(en[2]),
    .o_serial0_enable(en[1]), .o_timers_enable(en[0]), .o_gpio_func_gpio(fg),
    .o_gpio_oe(oe), .o_gpio_func_pci(fp), .o_gpio_func_alt(fa),
    .o_cfg_addr_bits_20_13(ca), .o_cfg_addr_bit7(c7), .o_cfg_host_width32(cw));
  task results;
    begin
      $display("errors %0d compared %0d", err_total, n_compared);
      if (err_total == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  task chk(input [15:0] got, input [15:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // Straps settle in reset; window checked mid-capture
  task boot(input [12:0] v);
    begin
      @(posedge i_clk);
      i_reset <= 1'b1;
      vec <= v;
      repeat (15) @(posedge i_clk);
      @(negedge i_clk);
      chk({3'h0, en}, 16'h0800);
      @(posedge i_clk);
      i_reset <= 1'b0;
      repeat (2) @(posedge i_clk);
      @(negedge i_clk);
      chk(fp | fg[15:9], 16'h0000);
      repeat (4) @(posedge i_clk);
      @(negedge i_clk);
    end
  endtask
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      err_total = err_total + 1;
      results;
    end
  end
  initial begin
    rv[0] = {3'h0, 8'hA4, 2'h2}; re[0] = 13'h0A87;
    rv[1] = {3'h5, 8'h5A, 2'h3}; re[1] = 13'h1587;
    rv[2] = {3'h2, 8'hC3, 2'h2}; re[2] = 13'h0A7B;
    rv[3] = {3'h7, 8'h81, 2'h3}; re[3] = 13'h1567;
    rv[4] = {3'h2, 8'h3C, 2'h3}; re[4] = 13'h0A73;
    for (i = 0; i < 5; i = i + 1) begin
      boot(rv[i]);
      chk({3'h0, en}, {3'h0, re[i]});
      chk({6'h00, cw, c7, ca}, {6'h00, rv[i][0], rv[i][1], rv[i][9:2]});
      chk(fp, rv[i][11] ? 16'hFE00 : 16'h0000);
    end
    boot(rv[2]);
    vec <= rv[2] | 13'h0400;
    repeat (4) @(posedge i_clk);
    @(negedge i_clk);
    chk({13'h0000, en[2], en[4], en[3]}, 16'h0005);
    @(posedge i_clk);
    // PCI kept fixed; only legal-to-ignore straps move
    vec <= (rv[2] | 13'h0400) ^ 13'h13FC;
    repeat (6) @(posedge i_clk);
    @(negedge i_clk);
    chk({3'h0, en}, 16'h0A6F);
    chk({6'h00, cw, c7, ca}, 16'h01C3);
    boot(rv[0]);
    chk(fa & 16'h01F6, 16'h01F6);
    chk(oe & 16'h00F6, 16'h0006);
    @(posedge i_clk);
    gen <= 16'hFE06;
    gdir <= 16'hAA02;
    repeat (2) @(posedge i_clk);
    @(negedge i_clk);
    chk(fg & 16'hFE06, 16'hFE06);
    chk(oe & 16'hFE06, 16'hAA02);
    chk(fp, 16'h0000);
    boot(rv[4]);
    chk(oe & 16'hFE00, 16'h0000);
    chk(fg & 16'h0006, 16'h0006);
    results;
  end
endmodule // tb_top
